// ==== src/ep_irq_pkg.sv ====
package ep_irq_pkg;
   localparam int unsigned          REG_W              = 16;
   localparam int unsigned          ADDR_W             = 12;
   localparam int unsigned          EP_COUNT           = 16;
   // printed offsets are not all multiples of four: keep them as indices
   localparam logic [ADDR_W-1:0]    TX_PENDING_IDX     = 12'h0002;
   localparam logic [ADDR_W-1:0]    RX_PENDING_IDX     = 12'h0004;
   localparam logic [ADDR_W-1:0]    TX_MASK_IDX        = 12'h0006;
   localparam logic [ADDR_W-1:0]    RX_MASK_IDX        = 12'h0008;
   localparam logic [ADDR_W-1:0]    CONFIGURED_IDX     = 12'h0010;
   localparam logic [ADDR_W-1:0]    IRQ_STATUS_IDX     = 12'h0011;
   localparam logic [ADDR_W-1:0]    IRQ_MASK_IDX       = 12'h0012;
   localparam logic [REG_W-1:0]     RX_PENDING_RESET   = 16'h0000;
   localparam logic [REG_W-1:0]     TX_PENDING_RESET   = 16'h0000;
   localparam logic [REG_W-1:0]     TX_MASK_RESET      = 16'hffff;
   localparam logic [REG_W-1:0]     RX_MASK_RESET      = 16'hfffe;
   localparam logic [REG_W-1:0]     CONFIGURED_RESET   = 16'h0000;
   localparam logic [REG_W-1:0]     RX_VALID_BITS      = 16'hfffe;
   localparam logic [1:0]           IRQ_STATUS_RESET   = 2'h0;
   localparam logic [1:0]           IRQ_MASK_RESET     = 2'h0;
   localparam int unsigned          IRQ_TX_BIT         = 0;
   localparam int unsigned          IRQ_RX_BIT         = 1;
   localparam int unsigned          CONTROL_EP_BIT     = 0;
endpackage : ep_irq_pkg

// ==== src/pending_bank.sv ====
`timescale 1ns/100ps
// sticky pending bits with read-to-clear; a set in the clearing cycle survives
module pending_bank
   import ep_irq_pkg::*;
#(
   parameter logic [REG_W-1:0] VALID = 16'hffff
) (
   input  wire logic              pclk,        // clock
   input  wire logic              presetn,     // async reset, low
   input  wire logic              ce,          // clock enable
   input  wire logic [REG_W-1:0]  event_in,    // event pulses
   input  wire logic [REG_W-1:0]  configured,  // endpoint configured
   input  wire logic              read_clear,  // destructive read
   output logic      [REG_W-1:0]  pending      // held bits
);
   logic [REG_W-1:0] next_pending;

   always_comb begin
      next_pending = pending;
      if (read_clear) begin
         next_pending = '0;
      end
      // unconfigured endpoints never latch
      next_pending = (next_pending | event_in) & configured & VALID;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= '0;
      end else if (ce) begin
         pending <= next_pending;
      end
   end
endmodule : pending_bank

// ==== src/sticky_bit.sv ====
`timescale 1ns/100ps
// one write-one-to-clear status bit; set beats clear
module sticky_bit (
   input  wire logic pclk,     // clock
   input  wire logic presetn,  // async reset, low
   input  wire logic ce,       // clock enable
   input  wire logic set,      // event
   input  wire logic clr,      // software clear
   output logic      q         // state
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= 1'b0;
      end else if (ce) begin
         q <= set | (q & ~clr);
      end
   end
endmodule : sticky_bit

// ==== src/usb_endpoint_irq_status_enable.sv ====
// Register access over APB was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - receive pending register, 16 bits, bits 15..1 flag receive endpoints 15..1.
// - bits of unconfigured endpoints always read zero.
// - reading the receive pending register returns bits then clears them.
// - receive pending resets to zero; bit 0 reserved, reads zero.
// - 16-bit transmit mask; set bit plus pending bit raises the usb interrupt.
// - cleared mask bit still lets pending bit set, but no usb interrupt; block_irq can still rise via irq_status.
// - transmit mask resets to all ones.
// - mask bit 0 gates the control endpoint, bits 15..1 transmit endpoints.
// - control endpoint transmit bit 0 sets on control in or out event.
module usb_endpoint_irq_status_enable
   import ep_irq_pkg::*;
(
   input  wire logic                       pclk,            // 100 MHz clock
   input  wire logic                       presetn,         // async reset, low
   input  wire logic                       ce,              // clock enable
   input  wire logic                       psel,            // apb select
   input  wire logic                       penable,         // apb access phase
   input  wire logic                       pwrite,          // apb write
   input  wire logic [ep_irq_pkg::ADDR_W+1:0] paddr,        // apb byte address
   input  wire logic [31:0]                pwdata,          // apb write data
   output logic      [31:0]                prdata,          // apb read data
   output logic                            pready,          // apb ready
   output logic                            pslverr,         // apb error
   input  wire logic [ep_irq_pkg::REG_W-1:0] tx_event,      // transmit endpoint events
   input  wire logic [ep_irq_pkg::REG_W-1:0] rx_event,      // receive endpoint events
   input  wire logic                       control_in_event,  // control in event
   input  wire logic                       control_out_event, // control out event
   output logic                            usb_irq,         // usb interrupt line
   output logic                            block_irq        // summary interrupt
);
   import ep_irq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [REG_W-1:0]  tx_mask;
   logic [REG_W-1:0]  rx_mask;
   logic [REG_W-1:0]  configured;
   logic [1:0]        irq_mask;
   logic [1:0]        irq_status;
   logic [REG_W-1:0]  tx_pending;
   logic [REG_W-1:0]  rx_pending;
   logic [REG_W-1:0]  tx_events_all;
   logic [ADDR_W-1:0] idx;
   logic              access;
   logic              wr;
   logic              rd;
   logic              mapped;
   logic              rx_read;
   logic              tx_read;
   logic [31:0]       next_prdata;
   logic              next_usb_irq;
   logic              tx_irq_evt;
   logic              rx_irq_evt;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // setup cycle answers with pready low, access phase takes two cycles with pready high in the second
   assign idx    = paddr[ADDR_W+1:2];
   assign access = psel & penable & ~pready;
   assign wr     = access & pwrite;
   assign rd     = access & ~pwrite;
   assign mapped = (idx == TX_PENDING_IDX) || (idx == RX_PENDING_IDX) || (idx == TX_MASK_IDX) ||
                   (idx == RX_MASK_IDX) || (idx == CONFIGURED_IDX) || (idx == IRQ_STATUS_IDX) ||
                   (idx == IRQ_MASK_IDX);
   assign rx_read = rd & (idx == RX_PENDING_IDX) & ce;
   assign tx_read = rd & (idx == TX_PENDING_IDX) & ce;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // control in and out share bit 0
   always_comb begin
      tx_events_all                 = tx_event;
      tx_events_all[CONTROL_EP_BIT] = tx_event[CONTROL_EP_BIT] | control_in_event | control_out_event;
   end

   pending_bank #(
      .VALID (16'hffff)
   ) u_tx_bank (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .event_in   (tx_events_all),
      .configured (configured),
      .read_clear (tx_read),
      .pending    (tx_pending)
   );

   pending_bank #(
      .VALID (RX_VALID_BITS)
   ) u_rx_bank (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .event_in   (rx_event),
      .configured (configured),
      .read_clear (rx_read),
      .pending    (rx_pending)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mask <= TX_MASK_RESET;
      end else if (ce && wr && idx == TX_MASK_IDX) begin
         tx_mask <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_mask <= RX_MASK_RESET;
      end else if (ce && wr && idx == RX_MASK_IDX) begin
         rx_mask <= pwdata[REG_W-1:0] & RX_VALID_BITS;
      end
   end

   // software marks which endpoints are configured; unconfigured ones stay silent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         configured <= CONFIGURED_RESET;
      end else if (ce && wr && idx == CONFIGURED_IDX) begin
         configured <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (ce && wr && idx == IRQ_MASK_IDX) begin
         irq_mask <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // summary sticky bits: rising edge of a new pending bit in either bank
   assign tx_irq_evt = |(tx_events_all & configured & ~tx_pending);
   assign rx_irq_evt = |(rx_event & configured & RX_VALID_BITS & ~rx_pending);

   sticky_bit u_tx_sticky (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (tx_irq_evt),
      .clr     (wr && idx == IRQ_STATUS_IDX && pwdata[IRQ_TX_BIT]),
      .q       (irq_status[IRQ_TX_BIT])
   );

   sticky_bit u_rx_sticky (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .set     (rx_irq_evt),
      .clr     (wr && idx == IRQ_STATUS_IDX && pwdata[IRQ_RX_BIT]),
      .q       (irq_status[IRQ_RX_BIT])
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_prdata = '0;
      unique case (idx)
         TX_PENDING_IDX: next_prdata[REG_W-1:0] = tx_pending;
         RX_PENDING_IDX: next_prdata[REG_W-1:0] = rx_pending & RX_VALID_BITS;
         TX_MASK_IDX:    next_prdata[REG_W-1:0] = tx_mask;
         RX_MASK_IDX:    next_prdata[REG_W-1:0] = rx_mask;
         CONFIGURED_IDX: next_prdata[REG_W-1:0] = configured;
         IRQ_STATUS_IDX: next_prdata[1:0]       = irq_status;
         IRQ_MASK_IDX:   next_prdata[1:0]       = irq_mask;
         default:        next_prdata = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (ce) begin
         pready  <= access;
         pslverr <= access & ~mapped;
         if (rd) begin
            prdata <= next_prdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // registered view of the enabled pending bits; next state so the line drops the cycle the clear lands
   always_comb begin
      next_usb_irq = |(tx_pending & tx_mask & ~{REG_W{tx_read}}) |
                     |(rx_pending & rx_mask & ~{REG_W{rx_read}}) |
                     |(tx_events_all & configured & tx_mask) |
                     |(rx_event & configured & rx_mask & RX_VALID_BITS);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_irq   <= 1'b0;
         block_irq <= 1'b0;
      end else if (ce) begin
         usb_irq   <= next_usb_irq;
         block_irq <= |(irq_status & irq_mask);
      end
   end
endmodule : usb_endpoint_irq_status_enable

// ==== verification/ep_event_src.sv ====
`timescale 1ns/100ps
// stands in for the protocol engine: events are single-cycle pulses, never levels
module ep_event_src (
   input  wire logic        pclk,     // clock
   input  wire logic        go,       // fire requested events
   input  wire logic [15:0] tx_req,   // tx endpoints to fire
   input  wire logic [15:0] rx_req,   // rx endpoints to fire
   input  wire logic        ci_req,   // fire control in
   input  wire logic        co_req,   // fire control out
   output logic      [15:0] tx_event, // tx pulses
   output logic      [15:0] rx_event, // rx pulses
   output logic             ci_event, // control in pulse
   output logic             co_event  // control out pulse
);
   always_ff @(posedge pclk) begin
      tx_event <= go ? tx_req : 16'h0000;
      rx_event <= go ? rx_req : 16'h0000;
      ci_event <= go && ci_req;
      co_event <= go && co_req;
   end
endmodule : ep_event_src

// ==== verification/ep_irq_chk.sv ====
`timescale 1ns/100ps
module ep_irq_chk
   import ep_irq_pkg::*;
(
   input wire logic              pclk,              // clock
   input wire logic              presetn,           // async reset, low
   input wire logic              ce,                // clock enable
   input wire logic              psel,              // apb select
   input wire logic              penable,           // apb access
   input wire logic              pwrite,            // apb write
   input wire logic [ADDR_W+1:0] paddr,             // byte address
   input wire logic [31:0]       prdata,            // read data
   input wire logic              pready,            // ready
   input wire logic              pslverr,           // error
   input wire logic [REG_W-1:0]  tx_event,          // tx events
   input wire logic [REG_W-1:0]  rx_event,          // rx events
   input wire logic              control_in_event,  // ctrl in
   input wire logic              control_out_event, // ctrl out
   input wire logic              usb_irq            // usb interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   logic cause;
   assign mapped = paddr[13:2] inside {TX_PENDING_IDX, RX_PENDING_IDX, TX_MASK_IDX, RX_MASK_IDX,
                                       CONFIGURED_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX};
   // a mask write may raise the line as well as an event
   assign cause = (|tx_event) || (|rx_event) || control_in_event || control_out_event || (psel && pwrite);
   sequence s_access;
      psel && penable && !pready && ce;
   endsequence
   sequence s_read_rx;
      pready && !pwrite && !pslverr && paddr[13:2] == RX_PENDING_IDX;
   endsequence
   a_ready_one_cycle: assert property (pready && ce |=> !pready) else $error("pready longer than one cycle");
   a_ready_after_access: assert property (s_access |=> pready) else $error("no answer after access");
   a_ready_needs_access: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("wrong error decode");
   a_err_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("error read returned data");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_rx_reserved_zero: assert property (s_read_rx |-> !prdata[0]) else $error("reserved rx bit set");
   a_irq_has_cause: assert property ($rose(usb_irq) |-> $past(cause) || $past(cause, 2))
      else $error("usb_irq rose without cause");
endmodule : ep_irq_chk
////////////////////////////////////////////////////////////////////////////////
bind usb_endpoint_irq_status_enable ep_irq_chk chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_event(tx_event), .rx_event(rx_event), .control_in_event(control_in_event),
   .control_out_event(control_out_event), .usb_irq(usb_irq));

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import ep_irq_pkg::*;
   logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic        go = 0, ci_req = 0, co_req = 0, pready, pslverr, usb_irq, block_irq, err, ci, co;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [15:0] tx_req = 16'h0000, rx_req = 16'h0000, tx_event, rx_event, r;
   int          errors = 0, checks = 0, seed = 29;
   always #5 pclk = ~pclk;
   usb_endpoint_irq_status_enable dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_event(tx_event), .rx_event(rx_event), .control_in_event(ci), .control_out_event(co),
      .usb_irq(usb_irq), .block_irq(block_irq));
   ep_event_src src_u (.pclk(pclk), .go(go), .tx_req(tx_req), .rx_req(rx_req), .ci_req(ci_req), .co_req(co_req),
      .tx_event(tx_event), .rx_event(rx_event), .ci_event(ci), .co_event(co));
   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // called just after a rising edge; pready is read before that edge's updates land
   task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      // a slave that never answers is a mismatch, not a silent pass
      if (pready !== 1'b1) chk("pready timeout", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask : apb
   task pulse(input logic [15:0] t, input logic [15:0] x, input logic i, input logic o);
      tx_req <= t; rx_req <= x; ci_req <= i; co_req <= o; go <= 1;
      @(posedge pclk);
      go <= 0;
      repeat (3) @(posedge pclk);
   endtask : pulse
   function automatic logic [31:0] rx_exp(input logic [15:0] ev);
      return {16'h0000, ev & 16'hfffe};
   endfunction : rx_exp
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, TX_MASK_IDX, 0); chk("tx_mask reset", rd, 32'h0000_ffff);
      apb(0, RX_PENDING_IDX, 0); chk("rx reset", rd, 32'h0000_0000);
      apb(0, 12'h0003, 0); chk("unmapped err", err, 1);
      pulse(16'hffff, 16'hffff, 1, 1);
      apb(0, RX_PENDING_IDX, 0); chk("rx unconfigured", rd, 32'h0000_0000);
      apb(0, TX_PENDING_IDX, 0); chk("tx unconfigured", rd, 32'h0000_0000);
      apb(1, CONFIGURED_IDX, 32'h0000_ffff);
      apb(1, IRQ_MASK_IDX, 32'h0000_0003);
      for (int k = 0; k < 8; k++) begin
         r = (k == 0) ? 16'h0001 : 16'($random(seed));
         pulse(16'h0000, r, 0, 0);
         chk("usb_irq rx", usb_irq, |(r & 16'hfffe));
         apb(0, RX_PENDING_IDX, 0); chk("rx pending", rd, rx_exp(r));
         apb(0, RX_PENDING_IDX, 0); chk("rx cleared", rd, 32'h0000_0000);
         chk("usb_irq dropped", usb_irq, 0);
      end
      apb(1, RX_MASK_IDX, 32'h0000_ffff);
      apb(0, RX_MASK_IDX, 0); chk("rx_mask rw", rd, 32'h0000_fffe);
      apb(1, RX_MASK_IDX, 32'h0000_0000);
      pulse(16'h0000, 16'h0004, 0, 0); chk("rx masked irq", usb_irq, 0);
      apb(0, RX_PENDING_IDX, 0); chk("rx masked pending", rd, 32'h0000_0004);
      // events while the clock enable is low must not latch
      ce <= 1'b0;
      pulse(16'h0000, 16'h0008, 0, 0);
      ce <= 1'b1;
      apb(0, RX_PENDING_IDX, 0); chk("frozen by ce", rd, 32'h0000_0000);
      apb(1, TX_MASK_IDX, 32'h0000_0000);
      pulse(16'h8000, 16'h0000, 0, 0); chk("masked irq", usb_irq, 0);
      apb(0, TX_PENDING_IDX, 0); chk("masked pending", rd, 32'h0000_8000);
      apb(1, TX_MASK_IDX, 32'h0000_0001);
      apb(0, TX_MASK_IDX, 0); chk("tx_mask rw", rd, 32'h0000_0001);
      pulse(16'h0002, 16'h0000, 0, 0); chk("ep1 gated", usb_irq, 0);
      apb(0, TX_PENDING_IDX, 0);
      pulse(16'h0000, 16'h0000, 1, 0); chk("ctrl in irq", usb_irq, 1);
      apb(0, TX_PENDING_IDX, 0); chk("ctrl in bit", rd, 32'h0000_0001);
      chk("irq after clear", usb_irq, 0);
      pulse(16'h0000, 16'h0000, 0, 1);
      apb(0, TX_PENDING_IDX, 0); chk("ctrl out bit", rd, 32'h0000_0001);
      chk("block raised", block_irq, 1);
      apb(1, IRQ_MASK_IDX, 32'h0000_0000); chk("block masked", block_irq, 0);
      apb(1, IRQ_MASK_IDX, 32'h0000_0003);
      apb(1, IRQ_STATUS_IDX, 32'h0000_0003); chk("block cleared", block_irq, 0);
      apb(0, IRQ_STATUS_IDX, 0); chk("status cleared", rd, 32'h0000_0000);
      // second reset in mid-run with state pending and the line high
      pulse(16'h0001, 16'h0010, 0, 0); chk("irq before reset", usb_irq, 1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq after reset", usb_irq, 0);
      apb(0, TX_MASK_IDX, 0); chk("tx_mask rereset", rd, 32'h0000_ffff);
      apb(0, RX_PENDING_IDX, 0); chk("rx rereset", rd, 32'h0000_0000);
      apb(0, TX_PENDING_IDX, 0); chk("tx rereset", rd, 32'h0000_0000);
      summarize;
   end
   // the sequence needs well under 2000 cycles
   initial begin
      #200000;
      errors++;
      summarize;
   end
endmodule : tb_top
